// [bus_master_model.sv]
// Behavioural two-wire bus master paced by the system clock
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    // Pacing clock and bus
    input wire logic clk_sys,
    input wire logic sda,
    output var logic scl,
    output var logic m_oe
);
    initial begin
        scl = 1'b1;
        m_oe = 1'b0;
    end
    task automatic wait_q();
        repeat (10) @(negedge clk_sys);
    endtask
    // Data moves mid low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        wait_q();
        m_oe = ~b;
        wait_q();
        scl = 1'b1;
        wait_q();
        r = sda;
        wait_q();
        scl = 1'b0;
    endtask
    // SDA falls or rises with SCL high; a stop leaves SCL high
    task automatic frame(input logic fall);
        wait_q();
        m_oe = ~fall;
        wait_q();
        scl = 1'b1;
        wait_q();
        m_oe = fall;
        wait_q();
        scl = ~fall;
    endtask
    // MSB first, slot nine driven as given
    task automatic xfer(input logic [7:0] b, input logic slot, output logic [7:0] got,
                        output logic lvl);
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], got[i]);
        end
        bit_io(slot, lvl);
    endtask
    // Nine clocks, then start and stop, to free a stuck bus
    task automatic recover();
        logic r;
        repeat (9) bit_io(1'b1, r);
        frame(1'b1);
        frame(1'b0);
    endtask
endmodule
`default_nettype wire

// [eeprom_checker_assertions.sv]
// Port assertions for the two-wire EEPROM target
`timescale 1ns/1ps
`default_nettype none
module eeprom_checker
    import eeprom_pkg::*;
#(
    parameter int WRITE_CYCLES = WRITE_CYCLE_COUNT
) (
    // Clocks and reset
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic link_clk,
    // Bus, pins and status
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_oe,
    input wire logic write_protect,
    input wire logic standby,
    input wire logic write_busy
);
    // Busy length so far, zero while idle
    int busy_cnt;
    always_ff @(posedge clk_sys) begin
        busy_cnt <= (reset || !write_busy) ? 0 : busy_cnt + 1;
    end
    ////////////////////////////////////////
    reset_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(reset) |-> standby && !sda_oe && !write_busy) else $error("not idle at reset");
    busy_standby_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(write_busy) |-> !standby) else $error("standby during write");
    busy_length_a: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(write_busy) |-> busy_cnt >= WRITE_CYCLES - 1 && busy_cnt <= WRITE_CYCLES + 2)
        else $error("write cycle length off");
    wp_block_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(write_busy) |-> !write_protect) else $error("write under protection");
    busy_mute_a: assert property (@(posedge link_clk) disable iff (reset)
        write_busy |-> !sda_oe) else $error("answer while busy");
    ack_scl_low_a: assert property (@(posedge link_clk) disable iff (reset)
        $changed(sda_oe) |-> !scl) else $error("data moved with clock high");
    start_wake_a: assert property (@(posedge link_clk) disable iff (reset)
        scl && $fell(sda_i) |-> ##[1:20] !standby) else $error("start not seen");
    ack_active_a: assert property (@(posedge link_clk) disable iff (reset)
        sda_oe |-> !standby) else $error("pull while in standby");
    cover property (@(posedge clk_sys) $rose(write_busy));
    cover property (@(posedge link_clk) $rose(sda_oe));
    cover property (@(posedge link_clk) $fell(standby));
endmodule
bind two_wire_eeprom_slave eeprom_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
    .clk_sys(clk_sys), .reset(reset), .link_clk(link_clk), .scl(scl), .sda_i(sda_i),
    .sda_oe(sda_oe), .write_protect(write_protect), .standby(standby),
    .write_busy(write_busy));
`default_nettype wire

// [eeprom_pkg.sv]
// Shared constants, types and timing for the two-wire serial EEPROM target
//
// Notes on behaviour
// R1: Smallest density: 256 pages of 64 bytes, 14-bit word address.
// R2: Middle density: 512 pages of 64 bytes, 15-bit word address.
// R3: Largest density: 512 pages of 128 bytes, 16-bit word address.
// R4: SDA changes only while SCL low; changes with SCL high are start/stop.
// R5: Start is SDA falling with SCL high; it begins a transaction.
// R6: Stop is SDA rising with SCL high; after a read, enter standby.
// R7: Words are 8 bits; device pulls SDA low on the ninth clock to acknowledge.
// R8: Master recovers the bus with up to 9 clocks, then a start.
// R9: Each start is followed by an 8-bit device address word.
// R10: Three chip-select bits must match the straps; floating straps read low.
// R11: Last address bit: one means read, zero means write.
// R12: Match is acknowledged; mismatch is not, and device returns to standby.
// R13: Write protect high inhibits all array writes; low allows normal writes.
// R14: Byte write commits on stop with a self-timed cycle ignoring inputs.
// R15: Page write takes up to 63 more bytes, each acknowledged, ended by stop.
// R16: Page write advances only the low six address bits, wrapping in page.
// R17: During the write cycle, device address is acknowledged only after completion.
// R18: Address counter holds last address plus one; reads wrap array end to zero.
// R19: Current-address read shifts out the byte at the counter.
// R20: Random read uses a dummy write of the word address, then a read.
// R21: Each master acknowledge sends the next byte; nack and stop end it.
// R22: SDA and SCL are filtered so short spikes cannot disturb transfers.
// R23: Data is sampled on rising SCL and launched after falling SCL.
// R24: Self-timed write cycle lasts at most 5 ms from the stop.
// R25: Device type nibble of the address word is binary 1010.
// R26: Largest density pages take 128 bytes, low seven bits wrapping.
package eeprom_pkg;

    typedef enum logic [1:0] {
        DENSITY_128K = 2'h0,
        DENSITY_256K = 2'h1,
        DENSITY_512K = 2'h2
    } density_e;

    localparam int ADDR_W = 16;
    localparam int MEM_DEPTH = 65536;
    localparam int PAGE_W = 7;
    localparam int HIGH_W = ADDR_W - PAGE_W;
    localparam int PAGE_DEPTH = 128;
    localparam logic [PAGE_W-1:0] PAGE_LAST = 7'h7f;
    localparam logic [ADDR_W-1:0] MASK_128K = 16'h3fff;
    localparam logic [ADDR_W-1:0] MASK_256K = 16'h7fff;
    localparam logic [ADDR_W-1:0] MASK_512K = 16'hffff;
    localparam logic [PAGE_W-1:0] PAGE_MASK_64 = 7'h3f;
    localparam logic [PAGE_W-1:0] PAGE_MASK_128 = 7'h7f;
    localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
    localparam logic [3:0] BITS_PER_WORD = 4'h8;

    localparam int SPIKE_NS = 50;
    localparam int LINK_PERIOD_NS = 12;
    localparam int FILTER_CYCLES = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int FILTER_CNT_W = 3;

    localparam int WRITE_TIME_MS = 5;
    localparam int CLK_SYS_KHZ = 50000;
    localparam int WRITE_CYCLE_COUNT = WRITE_TIME_MS * CLK_SYS_KHZ;
    localparam int TIMER_W = 18;

    typedef enum logic [10:0] {
        S_IDLE    = 11'h001,
        S_DEV     = 11'h002,
        S_DEV_ACK = 11'h004,
        S_HI      = 11'h008,
        S_HI_ACK  = 11'h010,
        S_LO      = 11'h020,
        S_LO_ACK  = 11'h040,
        S_WR      = 11'h080,
        S_WR_ACK  = 11'h100,
        S_RD      = 11'h200,
        S_RD_ACK  = 11'h400
    } link_state_e;

    typedef struct packed {
        logic wp;
        logic [2:0] strap;
        logic scl;
        logic sda;
    } pins_s;

    localparam pins_s PINS_IDLE = 6'h03;

    function automatic logic [ADDR_W-1:0] addr_mask(input density_e d);
        case (d)
            DENSITY_128K: addr_mask = MASK_128K;
            DENSITY_256K: addr_mask = MASK_256K;
            default: addr_mask = MASK_512K;
        endcase
    endfunction

    function automatic logic [PAGE_W-1:0] page_mask(input density_e d);
        page_mask = (d == DENSITY_512K) ? PAGE_MASK_128 : PAGE_MASK_64;
    endfunction

endpackage

// [pin_filter.sv]
// Two-stage synchroniser plus stability filter for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_filter #(
    parameter int WIDTH = 1,
    parameter int CYCLES = 1,
    parameter int CNT_W = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins in, cleaned levels out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(CYCLES - 1);

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta;
        logic sync;
        logic level;
        logic [CNT_W-1:0] cnt;

        always_ff @(posedge clk) begin
            meta <= din[i];
            sync <= meta;
        end

        // A new level must hold for the whole window before it is taken
        always_ff @(posedge clk) begin
            if (rst) begin
                level <= RESET_VAL[i];
                cnt <= '0;
            end else if (sync == level) begin
                cnt <= '0;
            end else if (cnt == CNT_MAX) begin
                level <= sync;
                cnt <= '0;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end

        assign dout[i] = level;
    end

endmodule

`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the two-wire EEPROM target
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import eeprom_pkg::*;
;
    localparam int WC = 1000;
    localparam logic [2:0] STRAP = 3'h5;
    // Straps are driven so the match logic sees more than one setting
    logic [2:0] strap = STRAP;
    logic clk_sys = 1'b0;
    logic link_clk = 1'b0;
    logic reset = 1'b1;
    logic write_protect = 1'b0;
    int fails = 0;
    int n_compared = 0;
    wire logic scl, m_oe, sda_o, sda_oe, standby, write_busy;
    // Pull-up: low when either side pulls; the target drives its own output value
    wire logic sda = (sda_oe ? sda_o : 1'b1) & ~m_oe;
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #3.7;
        forever #6 link_clk = ~link_clk;
    end
    two_wire_eeprom_slave #(.DENSITY(DENSITY_512K), .WRITE_CYCLES(WC)) dut_u (
        .clk_sys(clk_sys), .reset(reset), .link_clk(link_clk), .scl(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_strap_0(strap[0]),
        .chip_select_strap_1(strap[1]), .chip_select_strap_2(strap[2]),
        .write_protect(write_protect), .standby(standby), .write_busy(write_busy));
    bus_master_model master_u (.clk_sys(clk_sys), .sda(sda), .scl(scl), .m_oe(m_oe));
    ////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Bounded wait; running out ends the run
    task automatic wait_busy(input logic lvl);
        repeat (2000) begin
            if (write_busy === lvl) return;
            @(negedge clk_sys);
        end
        fails++;
        end_of_test();
    endtask
    task automatic put(input logic [7:0] b, input logic ack);
        logic [7:0] d;
        logic r;
        master_u.xfer(b, 1'b1, d, r);
        check({7'h0, r}, {7'h0, ~ack});
    endtask
    task automatic set_addr(input logic [15:0] a);
        master_u.frame(1'b1);
        put({4'ha, STRAP, 1'b0}, 1'b1);
        put(a[15:8], 1'b1);
        put(a[7:0], 1'b1);
    endtask
    // Dummy write, repeated start, read; nack on the last byte
    task automatic read_seq(input logic [15:0] a, input logic [7:0] exp[$]);
        logic [7:0] d;
        logic r;
        set_addr(a);
        master_u.frame(1'b1);
        put({4'ha, STRAP, 1'b1}, 1'b1);
        foreach (exp[i]) begin
            master_u.xfer(8'hff, i == exp.size() - 1, d, r);
            check(d, exp[i]);
        end
        master_u.frame(1'b0);
        repeat (40) @(negedge clk_sys);
        check({7'h0, standby}, 8'h01);
    endtask
    task automatic write_seq(input logic [15:0] a, input logic [7:0] d[$]);
        set_addr(a);
        foreach (d[i]) begin
            put(d[i], 1'b1);
        end
        master_u.frame(1'b0);
    endtask
    ////////////////////////////////////////
    task automatic s_write_poll();
        logic [7:0] d;
        logic r;
        write_seq(16'h0000, {8'h5a, 8'h3c});
        wait_busy(1'b1);
        master_u.frame(1'b1);
        put({4'ha, STRAP, 1'b0}, 1'b0);
        master_u.frame(1'b0);
        wait_busy(1'b0);
        repeat (40) @(negedge clk_sys);
        read_seq(16'h0000, {8'h5a});
        master_u.frame(1'b1);
        put({4'ha, STRAP, 1'b1}, 1'b1);
        master_u.xfer(8'hff, 1'b1, d, r);
        check(d, 8'h3c);
        master_u.frame(1'b0);
    endtask
    // Top page wraps within itself; reads wrap to zero
    task automatic s_wrap();
        write_seq(16'hffff, {8'ha1, 8'hb2, 8'hc3});
        wait_busy(1'b1);
        wait_busy(1'b0);
        repeat (40) @(negedge clk_sys);
        read_seq(16'hff80, {8'hb2, 8'hc3});
        read_seq(16'hffff, {8'ha1, 8'h5a});
    endtask
    // Every strap code, then a foreign type code 8'hba, under each of two strap settings
    task automatic s_foreign();
        for (int t = 0; t < 2; t++) begin
            strap = (t == 0) ? STRAP : 3'h2;
            for (int s = 0; s < 9; s++) begin
                master_u.frame(1'b1);
                put((s < 8) ? {4'ha, 3'(s), 1'b0} : 8'hba, s == strap);
                master_u.frame(1'b0);
            end
        end
        strap = STRAP;
    endtask
    task automatic s_protect();
        write_protect = 1'b1;
        write_seq(16'h0000, {8'hee});
        repeat (300) @(negedge clk_sys);
        check({7'h0, write_busy}, 8'h00);
        write_protect = 1'b0;
        read_seq(16'h0000, {8'h5a});
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        repeat (20) @(negedge clk_sys);
        master_u.recover();
        s_write_poll();
        s_wrap();
        s_foreign();
        s_protect();
        end_of_test();
    end
endmodule
`default_nettype wire

// [two_wire_eeprom_slave.sv]
// Two-wire serial EEPROM target: link engine, array and self-timed write cycle
`timescale 1ns/1ps
`default_nettype none

module two_wire_eeprom_slave
    import eeprom_pkg::*;
#(
    parameter density_e DENSITY = DENSITY_512K,
    parameter int WRITE_CYCLES = WRITE_CYCLE_COUNT
) (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Link sampling clock
    input wire logic link_clk,
    // Two-wire bus
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Straps and write protect
    input wire logic chip_select_strap_0,
    input wire logic chip_select_strap_1,
    input wire logic chip_select_strap_2,
    input wire logic write_protect,
    // Status
    output logic standby,
    output logic write_busy
);

    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(WRITE_CYCLES - 1);
    localparam logic [ADDR_W-1:0] AMASK = addr_mask(DENSITY);
    localparam logic [PAGE_W-1:0] PMASK = page_mask(DENSITY);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset into the link domain

    logic rst_meta;
    logic link_rst;

    always_ff @(posedge link_clk) begin
        rst_meta <= reset;
        link_rst <= rst_meta;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin conditioning and bus events

    pins_s raw;
    pins_s pins;
    logic scl_d;
    logic sda_d;

    assign raw = {write_protect, chip_select_strap_2, chip_select_strap_1,
                  chip_select_strap_0, scl, sda_i};

    pin_filter #(
        .WIDTH($bits(pins_s)),
        .CYCLES(FILTER_CYCLES),
        .CNT_W(FILTER_CNT_W),
        .RESET_VAL(PINS_IDLE)
    ) u_pin_filter (
        .clk(link_clk),
        .rst(link_rst),
        .din(raw),
        .dout(pins)
    ); // [R22] [R10]

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= pins.scl;
            sda_d <= pins.sda;
        end
    end

    wire scl_rise = pins.scl & ~scl_d;
    wire scl_fall = ~pins.scl & scl_d;
    wire start_cond = scl_d & pins.scl & sda_d & ~pins.sda; // [R4] [R5]
    wire stop_cond = scl_d & pins.scl & ~sda_d & pins.sda; // [R4] [R6]

    ////////////////////////////////////////////////////////////////////////////////
    // Link state and shared wires

    link_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic rd_mode;
    logic ack_seen;
    logic [ADDR_W-1:0] addr;
    logic [7:0] addr_hi;
    logic [ADDR_W-1:0] page_base;
    logic [PAGE_DEPTH-1:0] pend;
    logic [7:0] page_buf [PAGE_DEPTH];
    logic [7:0] mem [MEM_DEPTH];
    logic commit_run;
    logic [PAGE_W-1:0] commit_idx;
    logic wait_rise;
    logic wait_fall;
    logic req_tgl;
    logic busy_meta;
    logic busy_sync;

    wire link_busy = commit_run | wait_rise | wait_fall;
    wire byte_done = (bit_cnt == BITS_PER_WORD); // [R7]
    wire rx_state = (state == S_DEV) | (state == S_HI) | (state == S_LO) | (state == S_WR);
    wire [7:0] next_shreg = {shreg[6:0], pins.sda}; // [R23]
    wire dev_hit = (shreg[7:4] == DEV_TYPE_CODE) & (shreg[3:1] == pins.strap)
                   & ~link_busy; // [R9] [R25] [R10] [R17]
    wire [ADDR_W-1:0] word_addr = {addr_hi, shreg} & AMASK; // [R1] [R2] [R3]
    wire [PAGE_W-1:0] wr_offset = addr[PAGE_W-1:0] & PMASK;
    wire [PAGE_W-1:0] wr_step = (addr[PAGE_W-1:0] + 7'h01) & PMASK;
    wire [ADDR_W-1:0] next_wr_addr = (addr & ~{{HIGH_W{1'b0}}, PMASK})
                                     | {{HIGH_W{1'b0}}, wr_step}; // [R16] [R26]
    wire [ADDR_W-1:0] next_rd_addr = (addr + 16'h0001) & AMASK; // [R18] [R21]
    wire [7:0] rd_byte = mem[addr & AMASK]; // [R19]

    wire ev_hi = scl_fall & byte_done & (state == S_HI);
    wire ev_lo = scl_fall & byte_done & (state == S_LO);
    wire ev_wr = scl_fall & byte_done & (state == S_WR);
    wire ev_load = scl_fall & (((state == S_DEV_ACK) & rd_mode)
                               | ((state == S_RD_ACK) & ack_seen));
    wire launch = stop_cond & (|pend) & ~pins.wp & ~link_busy; // [R13] [R14]
    wire commit_end = commit_run & (commit_idx == PAGE_LAST);
    wire clear_pend = ((start_cond | stop_cond) & ~launch & ~commit_run) | commit_end;

    ////////////////////////////////////////////////////////////////////////////////
    // Link engine

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            state <= S_IDLE;
            bit_cnt <= '0;
            shreg <= '0;
            tx <= '0;
            rd_mode <= 1'b0;
            ack_seen <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_cond) begin
            state <= S_DEV; // [R5]
            bit_cnt <= '0;
            sda_oe <= 1'b0;
        end else if (stop_cond) begin
            state <= S_IDLE; // [R6]
            sda_oe <= 1'b0;
        end else begin
            if (scl_rise && rx_state && !byte_done) begin
                shreg <= next_shreg; // [R23]
                bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_rise && state == S_RD_ACK) begin
                ack_seen <= ~pins.sda; // [R21]
            end
            if (scl_fall) begin
                case (state)
                    S_DEV: begin
                        if (byte_done && dev_hit) begin
                            state <= S_DEV_ACK; // [R12]
                            sda_oe <= 1'b1;
                            rd_mode <= shreg[0]; // [R11]
                        end else if (byte_done) begin
                            state <= S_IDLE; // [R12]
                        end
                    end
                    S_HI: begin
                        if (byte_done) begin
                            state <= S_HI_ACK; // [R7]
                            sda_oe <= 1'b1;
                        end
                    end
                    S_LO: begin
                        if (byte_done) begin
                            state <= S_LO_ACK; // [R7]
                            sda_oe <= 1'b1;
                        end
                    end
                    S_WR: begin
                        if (byte_done) begin
                            state <= S_WR_ACK; // [R15]
                            sda_oe <= 1'b1;
                        end
                    end
                    S_DEV_ACK: begin
                        if (rd_mode) begin
                            state <= S_RD; // [R19]
                            sda_oe <= ~rd_byte[7];
                            tx <= {rd_byte[6:0], 1'b0};
                            bit_cnt <= 4'h1;
                        end else begin
                            state <= S_HI;
                            sda_oe <= 1'b0;
                            bit_cnt <= '0;
                        end
                    end
                    S_HI_ACK: begin
                        state <= S_LO;
                        sda_oe <= 1'b0;
                        bit_cnt <= '0;
                    end
                    S_LO_ACK, S_WR_ACK: begin
                        state <= S_WR; // [R15] [R20]
                        sda_oe <= 1'b0;
                        bit_cnt <= '0;
                    end
                    S_RD: begin
                        if (byte_done) begin
                            state <= S_RD_ACK;
                            sda_oe <= 1'b0;
                        end else begin
                            sda_oe <= ~tx[7]; // [R23]
                            tx <= {tx[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                    S_RD_ACK: begin
                        if (ack_seen) begin
                            state <= S_RD; // [R21]
                            sda_oe <= ~rd_byte[7];
                            tx <= {rd_byte[6:0], 1'b0};
                            bit_cnt <= 4'h1;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    assign sda_o = 1'b0;

    // Counter survives between transactions; only reset clears it
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            addr <= '0;
            addr_hi <= '0;
            page_base <= '0;
        end else if (ev_hi) begin
            addr_hi <= shreg;
        end else if (ev_lo) begin
            addr <= word_addr; // [R18] [R20]
            page_base <= word_addr & ~{{HIGH_W{1'b0}}, PMASK};
        end else if (ev_wr) begin
            addr <= next_wr_addr; // [R16] [R26]
        end else if (ev_load) begin
            addr <= next_rd_addr; // [R18] [R21]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Page buffer and commit

    // Bytes wait here so an aborted sequence never touches the array
    always_ff @(posedge link_clk) begin
        if (ev_wr) begin
            page_buf[wr_offset] <= shreg; // [R15] [R16]
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst || clear_pend) begin
            pend <= '0;
        end else if (ev_wr) begin
            pend[wr_offset] <= 1'b1;
        end
    end

    always_ff @(posedge link_clk) begin
        if (commit_run && pend[commit_idx]) begin
            mem[page_base | {{HIGH_W{1'b0}}, commit_idx}] <= page_buf[commit_idx]; // [R14]
        end
    end

    // Busy holds until the timer has risen and fallen again
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            commit_run <= 1'b0;
            commit_idx <= '0;
            wait_rise <= 1'b0;
            wait_fall <= 1'b0;
            req_tgl <= 1'b0;
        end else if (launch) begin
            commit_run <= 1'b1; // [R14]
            commit_idx <= '0;
            wait_rise <= 1'b1;
            req_tgl <= ~req_tgl;
        end else begin
            if (commit_run) begin
                commit_idx <= commit_idx + 7'h01;
                commit_run <= ~commit_end;
            end
            if (wait_rise && busy_sync) begin
                wait_rise <= 1'b0;
                wait_fall <= 1'b1;
            end
            if (wait_fall && !busy_sync) begin
                wait_fall <= 1'b0; // [R17]
            end
        end
    end

    always_ff @(posedge link_clk) begin
        busy_meta <= write_busy;
        busy_sync <= busy_meta;
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            standby <= 1'b1;
        end else begin
            standby <= (state == S_IDLE) & ~link_busy; // [R6]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Self-timed write cycle on the system clock

    logic req_meta;
    logic req_sync;
    logic req_seen;
    logic [TIMER_W-1:0] timer;

    always_ff @(posedge clk_sys) begin
        req_meta <= req_tgl;
        req_sync <= req_meta;
    end

    wire cycle_start = req_sync ^ req_seen;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            req_seen <= 1'b0;
            write_busy <= 1'b0;
            timer <= '0;
        end else begin
            req_seen <= req_sync;
            if (cycle_start) begin
                write_busy <= 1'b1; // [R14]
                timer <= '0;
            end else if (write_busy && timer == TIMER_LAST) begin
                write_busy <= 1'b0; // [R24]
            end else if (write_busy) begin
                timer <= timer + 18'h00001;
            end
        end
    end

endmodule

`default_nettype wire
